// ==== rcw_pkg.sv ====
/*
  Package for the runaway-code watchdog: register map, field positions,
  reset values, timing counts and the grouped input carriers.
  Assumes a 32-bit AHB-Lite register bus and a 40 MHz block clock that
  stands in for the crystal clock.
*/
package rcw_pkg;

  // block clock and the crystal reference used for the nominal timeout figure
  localparam int unsigned CLK_HZ           = 40000000;
  localparam int unsigned XTAL_REF_HZ      = 4915200;
  localparam int unsigned TIMEOUT_REF_US   = 53300;

  // counter geometry
  localparam int unsigned PRE_W            = 12;
  localparam int unsigned CNT_W            = 6;
  localparam int unsigned TOT_W            = PRE_W + CNT_W;
  localparam int unsigned SVC_KEEP_LSB     = 3;

  // overflow counts in crystal cycles; select value 0 picks the long one
  localparam int unsigned LONG_TIMEOUT_CYC  = (1 << 18) - (1 << 4);
  localparam int unsigned SHORT_TIMEOUT_CYC = (1 << 13) - (1 << 4);
  localparam int unsigned POR_CLEAR_CYC     = 4096;
  localparam int unsigned RST_PULSE_CYC     = 32;

  // register map: the service location is an index, the rest are byte addresses
  localparam logic [31:0] SERVICE_INDEX    = 32'h0000FFFF;
  localparam logic [31:0] SERVICE_ADDR     = SERVICE_INDEX << 2;
  localparam logic [31:0] CAUSE_ADDR       = 32'h00000000;
  localparam logic [31:0] STATUS_ADDR      = 32'h00000004;
  localparam logic [31:0] MASK_ADDR        = 32'h00000008;
  localparam logic [31:0] COUNT_ADDR       = 32'h0000000C;

  // field positions
  localparam int unsigned CAUSE_WDOG_BIT   = 0;
  localparam int unsigned EV_FIRE_BIT      = 0;
  localparam int unsigned EV_QUIET_BIT     = 1;
  localparam int unsigned EV_W             = 2;

  // reset values
  localparam logic [EV_W-1:0] MASK_RST     = 2'h0;
  localparam logic [31:0]     RDATA_RST    = 32'h00000000;

  // mask-option bits, fixed at manufacture
  typedef struct packed {
    logic disable_opt;
    logic length_sel;
    logic stop_en;
  } rcw_opts_t;

  // operating conditions reported by the rest of the chip
  typedef struct packed {
    logic monitor;
    logic brk;
    logic rst_hv;
    logic irq_hv;
    logic stop_mode;
    logic wait_mode;
  } rcw_modes_t;

  typedef enum logic {ST_RUN, ST_FIRE} rcw_state_t;

endpackage

// ==== rcw_watchdog.sv ====
/*
  Runaway-code watchdog: prescaler plus counter, service location and
  forced-reset pulse on the open-drain reset pin, behind an AHB-Lite slave.
  Assumes clk_in is the crystal clock, all inputs synchronous to it, and
  that the chip's reset controller turns the pin pulse into an internal reset.

*/
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module rcw_watchdog #(
  parameter int unsigned LONG_COUNT  = rcw_pkg::LONG_TIMEOUT_CYC,
  parameter int unsigned SHORT_COUNT = rcw_pkg::SHORT_TIMEOUT_CYC
) (
  input  wire logic               clk_in,
  input  wire logic               reset_in,
  input  wire logic               hsel_in,
  input  wire logic [31:0]        haddr_in,
  input  wire logic [1:0]         htrans_in,
  input  wire logic               hwrite_in,
  input  wire logic [2:0]         hsize_in,
  input  wire logic [31:0]        hwdata_in,
  input  wire logic               hready_in,
  output logic [31:0]             hrdata_out,
  output logic                    hreadyout_out,
  output logic                    hresp_out,
  input  wire rcw_pkg::rcw_opts_t  opts_in,
  input  wire rcw_pkg::rcw_modes_t modes_in,
  input  wire logic               stop_instr_in,
  input  wire logic               internal_reset_in,
  input  wire logic               vector_fetch_in,
  input  wire logic [7:0]         reset_vector_low_in,
  output logic                    rst_pin_out,
  output logic                    rst_pin_oe_out,
  output logic                    event_irq_out
);
  import rcw_pkg::*;

  localparam logic [TOT_W-1:0] LONG_LAST  = TOT_W'(LONG_COUNT - 1);
  localparam logic [TOT_W-1:0] SHORT_LAST = TOT_W'(SHORT_COUNT - 1);
  localparam logic [5:0]       PULSE_LAST = 6'(RST_PULSE_CYC - 1);
  localparam logic [12:0]      POR_LAST   = 13'(POR_CLEAR_CYC - 1);

  logic [PRE_W-1:0] pre_r;
  logic [CNT_W-1:0] cnt_r;
  logic [TOT_W-1:0] tot_nxt;
  rcw_state_t       state_r;
  logic [5:0]       pulse_cnt_r;
  logic [12:0]      por_cnt_r;
  logic             por_done_r;
  logic             cause_r;
  logic [EV_W-1:0]  status_r;
  logic [EV_W-1:0]  mask_r;
  logic             dp_wr_r;
  logic [31:0]      dp_addr_r;
  logic [31:0]      hrdata_r;

  // bus decode: zero-wait slave, so every accepted address phase is
  // followed by exactly one data phase
  wire              ap_valid   = hsel_in & htrans_in[1] & hready_in;
  wire              ap_read    = ap_valid & ~hwrite_in;
  wire              wr_service = dp_wr_r & (dp_addr_r == SERVICE_ADDR);
  wire              wr_cause   = dp_wr_r & (dp_addr_r == CAUSE_ADDR);
  wire              wr_status  = dp_wr_r & (dp_addr_r == STATUS_ADDR);
  wire              wr_mask    = dp_wr_r & (dp_addr_r == MASK_ADDR);

  // disable sources are mask options and test-voltage conditions only
  wire disabled = opts_in.disable_opt
                | (modes_in.monitor & (modes_in.rst_hv | modes_in.irq_hv))
                | (modes_in.brk & modes_in.rst_hv);

  // wait mode is deliberately absent here: the count keeps running
  wire halt       = modes_in.stop_mode & opts_in.stop_en;
  wire tick       = ~halt;
  wire [TOT_W-1:0] total = {cnt_r, pre_r};
  wire [TOT_W-1:0] limit = opts_in.length_sel ? SHORT_LAST : LONG_LAST;
  wire expired    = tick & (total >= limit);
  wire fire       = expired & ~disabled & (state_r == ST_RUN);
  wire quiet_exp  = expired & disabled;
  wire por_clear  = (por_cnt_r == POR_LAST) & ~por_done_r;
  wire clear_pre  = (stop_instr_in & opts_in.stop_en)
                  | vector_fetch_in
                  | por_clear;
  wire clear_all  = internal_reset_in | (state_r == ST_FIRE);
  wire [EV_W-1:0] ev_set = {quiet_exp, fire};

  always_comb begin
    tot_nxt = tick ? TOT_W'(total + 1'b1) : total;
    if (expired) begin
      tot_nxt = '0;
    end
    if (wr_service) begin
      tot_nxt[TOT_W-1:SVC_KEEP_LSB] = '0;
    end
    if (clear_pre) begin
      tot_nxt[PRE_W-1:0] = '0;
    end
    if (clear_all) begin
      tot_nxt = '0;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      pre_r <= '0;
      cnt_r <= '0;
    end else begin
      {cnt_r, pre_r} <= tot_nxt;
    end
  end

  // pulse on the reset pin; the counter is held clear while it runs
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_r     <= ST_RUN;
      pulse_cnt_r <= '0;
    end else begin
      case (state_r)
        ST_RUN: begin
          pulse_cnt_r <= '0;
          if (fire) begin
            state_r <= ST_FIRE;
          end
        end
        ST_FIRE: begin
          pulse_cnt_r <= pulse_cnt_r + 6'h01;
          if (pulse_cnt_r == PULSE_LAST) begin
            state_r <= ST_RUN;
          end
        end
        default: begin
          state_r <= ST_RUN;
        end
      endcase
    end
  end

  assign rst_pin_out    = 1'b0;
  assign rst_pin_oe_out = (state_r == ST_FIRE);

  // power-up delay before the one-off prescaler clear
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      por_cnt_r  <= '0;
      por_done_r <= 1'b0;
    end else if (!por_done_r) begin
      por_cnt_r  <= por_cnt_r + 13'h0001;
      por_done_r <= por_clear;
    end
  end

  // cause bit: a new overflow wins over a software clear in the same cycle
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      cause_r <= 1'b0;
    end else begin
      cause_r <= fire | (cause_r & ~(wr_cause & hwdata_in[CAUSE_WDOG_BIT]));
    end
  end

  // event status for the bus side only; this is not a processor interrupt
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      status_r <= '0;
      mask_r   <= MASK_RST;
    end else begin
      status_r <= ev_set | (status_r & ~({EV_W{wr_status}} & hwdata_in[EV_W-1:0]));
      if (wr_mask) begin
        mask_r <= hwdata_in[EV_W-1:0];
      end
    end
  end

  assign event_irq_out = |(status_r & mask_r);

  // read data is captured in the address phase so it stands from a flop
  wire [31:0] rd_mux =
      (haddr_in == SERVICE_ADDR) ? {24'h000000, reset_vector_low_in} :
      (haddr_in == CAUSE_ADDR)   ? {31'h00000000, cause_r} :
      (haddr_in == STATUS_ADDR)  ? {30'h00000000, status_r} :
      (haddr_in == MASK_ADDR)    ? {30'h00000000, mask_r} :
      (haddr_in == COUNT_ADDR)   ? {14'h0000, total} :
                                   RDATA_RST;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      dp_wr_r   <= 1'b0;
      dp_addr_r <= '0;
      hrdata_r  <= RDATA_RST;
    end else begin
      dp_wr_r   <= ap_valid & hwrite_in;
      dp_addr_r <= haddr_in;
      if (ap_read) begin
        hrdata_r <= rd_mux;
      end
    end
  end

  assign hrdata_out    = hrdata_r;
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  chk_pulse_width: assert property (
    $rose(rst_pin_oe_out) |-> rst_pin_oe_out ##31 rst_pin_oe_out ##1 !rst_pin_oe_out
  ) else $error("reset pin pulse is not 32 cycles");

  chk_cause_flag: assert property (
    fire |=> cause_r && rst_pin_oe_out
  ) else $error("overflow did not set cause and drive the pin");

  chk_disabled_quiet: assert property (
    $rose(rst_pin_oe_out) |-> !$past(disabled) && $past(total) >= $past(limit)
  ) else $error("reset pulse without an enabled overflow");

  chk_service_clear: assert property (
    wr_service && !clear_all |=> cnt_r == '0 && pre_r[PRE_W-1:SVC_KEEP_LSB] == '0
  ) else $error("service write did not clear the count");

  chk_stop_freeze: assert property (
    halt && !wr_service && !clear_pre && !clear_all |=> $stable(total)
  ) else $error("count moved during stop");

  chk_vector_read: assert property (
    ap_read && haddr_in == SERVICE_ADDR |=> hrdata_out == {24'h000000, $past(reset_vector_low_in)}
  ) else $error("service read did not return the vector byte");

  chk_internal_clear: assert property (
    internal_reset_in |=> total == '0
  ) else $error("internal reset left a count");

  chk_fetch_clear: assert property (
    vector_fetch_in |=> pre_r == '0
  ) else $error("vector fetch did not clear the prescaler");

  chk_por_clear: assert property (
    $rose(por_done_r) |-> pre_r == '0 && $past(por_cnt_r) == POR_LAST
  ) else $error("power-up prescaler clear mistimed");

  chk_wait_runs: assert property (
    modes_in.wait_mode && !halt && !expired && !wr_service && !clear_pre && !clear_all
      |=> total == $past(total) + 1'b1
  ) else $error("count stalled in wait mode");

  // independent length count of the pin pulse; the width checks
  // must not lean on pulse_cnt_r, which is what they verify
  logic [6:0] pin_low_len_r;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      pin_low_len_r <= '0;
    end else if (rst_pin_oe_out) begin
      pin_low_len_r <= pin_low_len_r + 7'h01;
    end else begin
      pin_low_len_r <= '0;
    end
  end

  chk_pulse_count: assert property (
    $fell(rst_pin_oe_out) |-> $past(pin_low_len_r) == 7'(RST_PULSE_CYC - 1)
  ) else $error("reset pin pulse length differs from 32 cycles");

  chk_pulse_bound: assert property (
    rst_pin_oe_out |-> pin_low_len_r < 7'(RST_PULSE_CYC)
  ) else $error("reset pin held low too long");

  chk_count_held: assert property (
    rst_pin_oe_out |-> total == '0
  ) else $error("count ran during the reset pulse");

  chk_pin_low: assert property (
    rst_pin_oe_out |-> !rst_pin_out
  ) else $error("reset pin enabled without driving low");

  // each test-voltage or option condition blocks a new pulse on its own
  chk_monitor_hv: assert property (
    modes_in.monitor && (modes_in.rst_hv || modes_in.irq_hv) |=> !$rose(rst_pin_oe_out)
  ) else $error("pulse while monitor test voltage present");

  chk_break_hv: assert property (
    modes_in.brk && modes_in.rst_hv |=> !$rose(rst_pin_oe_out)
  ) else $error("pulse while break test voltage present");

  chk_option_off: assert property (
    opts_in.disable_opt |=> !$rose(rst_pin_oe_out)
  ) else $error("pulse while disabled by option");

  chk_stop_no_fire: assert property (
    halt |=> !$rose(rst_pin_oe_out)
  ) else $error("pulse while the count is halted");

  chk_stop_clear: assert property (
    stop_instr_in && opts_in.stop_en |=> pre_r == '0
  ) else $error("stop instruction left a prescaler value");

  // the overflow lands exactly on the selected count, never beyond it
  chk_timeout_point: assert property (
    fire
      |-> total == (opts_in.length_sel ? SHORT_LAST : LONG_LAST)
  ) else $error("overflow at the wrong count");

  chk_wait_fire: assert property (
    modes_in.wait_mode && fire |=> rst_pin_oe_out
  ) else $error("overflow in wait mode gave no pulse");

  chk_quiet_event: assert property (
    quiet_exp |=> status_r[EV_QUIET_BIT] && total == '0
  ) else $error("silent wrap not recorded or count not cleared");

  // cause and status bits follow set-wins-over-clear
  chk_fire_event: assert property (
    fire |=> status_r[EV_FIRE_BIT]
  ) else $error("overflow not recorded in status");

  chk_cause_origin: assert property (
    $rose(cause_r) |-> $past(fire)
  ) else $error("cause bit set without an overflow");

  chk_cause_sticky: assert property (
    cause_r && !(wr_cause && hwdata_in[CAUSE_WDOG_BIT]) |=> cause_r
  ) else $error("cause bit dropped without a clear");

  chk_cause_clear: assert property (
    wr_cause && hwdata_in[CAUSE_WDOG_BIT] && !fire |=> !cause_r
  ) else $error("cause bit survived a clear");

  chk_status_clear: assert property (
    wr_status && hwdata_in[EV_FIRE_BIT] && !fire |=> !status_r[EV_FIRE_BIT]
  ) else $error("status bit survived a clear");

  // the three lowest prescaler stages keep running through a service write
  chk_service_low: assert property (
    wr_service && tick && !expired && !clear_pre && !clear_all
      |=> pre_r[SVC_KEEP_LSB-1:0] == $past(pre_r[SVC_KEEP_LSB-1:0]) + 1'b1
  ) else $error("service write disturbed the lowest prescaler stages");

  chk_por_once: assert property (
    por_done_r |=> por_done_r
  ) else $error("power-up clear armed again");

  // read data comes from a flop and stands until the next read
  chk_read_stands: assert property (
    !ap_read |=> $stable(hrdata_out)
  ) else $error("read data moved without a read");

  // the event line is a bus-side flag: it rises only on an event or a mask write
  chk_event_cause: assert property (
    $rose(event_irq_out) |-> $past(wr_mask) || $past(|ev_set)
  ) else $error("event line rose without an event");

endmodule

`default_nettype wire

// ==== test_runaway_code_watchdog.sv ====
/*
  Self-checking bench for the runaway-code watchdog: AHB-Lite register
  access, timeouts, reset pulse, disable conditions, stop, event line.
  Assumes rcw_pkg and rcw_watchdog are compiled first; checks sit in the design.
*/
`timescale 1ns/10ps
`default_nettype none

module test_runaway_code_watchdog;
  import rcw_pkg::*;
  // small counts keep the run short; expectations derive from these
  localparam int LC = 64;
  localparam int SC = 40;
  logic        clk_in   = 1'b0;
  logic        reset_in = 1'b1;
  logic        hsel     = 1'b0;
  logic [31:0] haddr    = 32'h00000000;
  logic [1:0]  htrans   = 2'h0;
  logic        hwrite   = 1'b0;
  logic [31:0] hwdata   = 32'h00000000;
  logic [31:0] hrdata;
  logic        hrdy;
  logic        hresp;
  rcw_opts_t   opts     = rcw_opts_t'(3'h0);
  rcw_modes_t  modes    = rcw_modes_t'(6'h00);
  logic        stop_i   = 1'b0;
  logic        int_rst  = 1'b0;
  logic        vfetch   = 1'b0;
  logic [7:0]  vec_low  = 8'hA5;
  logic        pin;
  logic        oe;
  logic        irq;
  int          err_total   = 0;
  int          check_count = 0;
  int          seed        = 77;
  int          n;
  int          m;
  int          i;
  int          k;
  logic [31:0] rd;
  logic [5:0]  hv_tab [3] = '{6'h28, 6'h24, 6'h18};

  always #12.5 clk_in = ~clk_in;

  rcw_watchdog #(.LONG_COUNT(LC), .SHORT_COUNT(SC)) u_dut (
    .clk_in(clk_in), .reset_in(reset_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
    .opts_in(opts), .modes_in(modes), .stop_instr_in(stop_i),
    .internal_reset_in(int_rst), .vector_fetch_in(vfetch),
    .reset_vector_low_in(vec_low), .rst_pin_out(pin), .rst_pin_oe_out(oe),
    .event_irq_out(irq));

  task end_sim;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task cmp_range(input int got, input int lo, input int hi, input string what);
    check_count++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("BAD %0t %s cycles %0d", $time, what, got);
    end
  endtask

  task wait_rdy;
    i = 0;
    do begin
      @(posedge clk_in);
      i++;
    end while (hrdy !== 1'b1 && i < 50);
    if (hrdy !== 1'b1) begin
      err_total++;
      end_sim;
    end
  endtask

  task bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy;
    rd = hrdata;
  endtask

  task svc;
    bus(1'b1, SERVICE_ADDR, $random(seed));
  endtask

  task quiet(input int c);
    k = 0;
    repeat (c) begin
      @(posedge clk_in);
      if (oe !== 1'b0) k++;
    end
    cmp_word(k, 0, "reset pulse while held off");
  endtask

  task tmo(input int lo, input int hi);
    n = 0;
    while (oe !== 1'b1 && n < hi + 8) begin
      @(posedge clk_in);
      n++;
    end
    cmp_range(n, lo, hi, "timeout");
    m = 0;
    while (oe === 1'b1 && m < 40) begin
      @(posedge clk_in);
      m++;
    end
    cmp_range(m, RST_PULSE_CYC, RST_PULSE_CYC, "pulse width");
  endtask

  initial begin
    repeat (60000) @(posedge clk_in);
    err_total++;
    end_sim;
  end

  initial begin
    repeat (16) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    cmp_word({hrdy, hresp, oe, irq, pin}, 32'h10, "idle outputs");
    bus(1'b0, CAUSE_ADDR, 0);
    cmp_word(rd, 0, "cause reset");
    bus(1'b0, MASK_ADDR, 0);
    cmp_word(rd, 0, "mask reset");
    bus(1'b0, 32'h00000040, 0);
    cmp_word(rd, 0, "unmapped read");
    // disabled across the power-up prescaler clear so later timings are clean
    opts <= rcw_opts_t'(3'h4);
    svc;
    quiet(4200);
    bus(1'b0, STATUS_ADDR, 0);
    cmp_word(rd & 32'h2, 32'h2, "silent wrap");
    svc;
    bus(1'b1, STATUS_ADDR, 32'h3);
    // option off, so only the test-voltage conditions hold the pulse back
    opts <= rcw_opts_t'(3'h0);
    for (int j = 0; j < 3; j++) begin
      modes <= rcw_modes_t'(hv_tab[j]);
      quiet(3 * LC);
    end
    svc;
    modes <= rcw_modes_t'(6'h00);
    opts  <= rcw_opts_t'(3'h0);
    bus(1'b0, CAUSE_ADDR, 0);
    cmp_word(rd, 0, "cause after disabled runs");
    bus(1'b1, MASK_ADDR, 32'h1);
    svc;
    tmo(LC - 8, LC + 1);
    svc;
    cmp_word(irq, 1, "event line unmasked");
    bus(1'b0, CAUSE_ADDR, 0);
    cmp_word(rd, 1, "cause set");
    bus(1'b1, MASK_ADDR, 0);
    @(posedge clk_in);
    cmp_word(irq, 0, "event line masked");
    bus(1'b1, MASK_ADDR, 32'h1);
    bus(1'b1, STATUS_ADDR, 32'h3);
    bus(1'b1, CAUSE_ADDR, 32'h1);
    @(posedge clk_in);
    cmp_word(irq, 0, "event cleared");
    bus(1'b0, CAUSE_ADDR, 0);
    cmp_word(rd, 0, "cause cleared");
    opts  <= rcw_opts_t'(3'h2);
    modes <= rcw_modes_t'(6'h01);
    svc;
    tmo(SC - 8, SC + 1);
    svc;
    modes <= rcw_modes_t'(6'h00);
    // random service spacing and reads of the shared location
    repeat (12) begin
      vec_low <= 8'($random(seed));
      quiet({$random(seed)} % 20 + 1);
      bus(1'b0, SERVICE_ADDR, 0);
      cmp_word(rd, {24'h000000, vec_low}, "service read");
      svc;
    end
    opts   <= rcw_opts_t'(3'h1);
    stop_i <= 1'b1;
    modes  <= rcw_modes_t'(6'h02);
    svc;
    stop_i <= 1'b0;
    quiet(3 * LC);
    bus(1'b0, COUNT_ADDR, 0);
    cmp_word(rd, 0, "count frozen in stop");
    modes <= rcw_modes_t'(6'h00);
    svc;
    opts  <= rcw_opts_t'(3'h0);
    modes <= rcw_modes_t'(6'h02);
    svc;
    tmo(LC - 8, LC + 1);
    modes   <= rcw_modes_t'(6'h00);
    int_rst <= 1'b1;
    quiet(3 * LC);
    bus(1'b0, COUNT_ADDR, 0);
    cmp_word(rd, 0, "count held clear");
    int_rst <= 1'b0;
    tmo(LC - 2, LC + 2);
    svc;
    repeat (3 * LC / 8) begin
      vfetch <= 1'b1;
      @(posedge clk_in);
      vfetch <= 1'b0;
      quiet(7);
    end
    end_sim;
  end
endmodule

`default_nettype wire
